/* File: core/seqls_consts.svh */
// Constants for the sequencer loop and stack unit.
// Assumes inclusion by bare name from the package and the core module.
`ifndef SEQLS_CONSTS_SVH
`define SEQLS_CONSTS_SVH

// ******************************************************************
// Widths and depths
// ******************************************************************
`define SEQLS_ADDR_W      14
`define SEQLS_COND_W      4
`define SEQLS_PCS_DEPTH   16
`define SEQLS_CNTS_DEPTH  4
`define SEQLS_LOOPS_DEPTH 4
`define SEQLS_CE_VALUE    14'h0001
`define SEQLS_CNT_RESET   14'h0000

// ******************************************************************
// Register byte offsets on the bus
// ******************************************************************
`define SEQLS_OFS_CNT     8'h00
`define SEQLS_OFS_STAT    8'h04
`define SEQLS_OFS_IP      8'h08

// ******************************************************************
// Status register bit positions
// ******************************************************************
`define SEQLS_ST_PCS_EMPTY   0
`define SEQLS_ST_PCS_OVF     1
`define SEQLS_ST_CNTS_EMPTY  2
`define SEQLS_ST_CNTS_OVF    3
`define SEQLS_ST_LOOPS_EMPTY 4
`define SEQLS_ST_LOOPS_OVF   5
`define SEQLS_ST_CNT_VALID   6

// ******************************************************************
// Branch condition field codes (branch sense)
// ******************************************************************
`define SEQLS_C_EQ     4'h0
`define SEQLS_C_NE     4'h1
`define SEQLS_C_GT     4'h2
`define SEQLS_C_LE     4'h3
`define SEQLS_C_LT     4'h4
`define SEQLS_C_GE     4'h5
`define SEQLS_C_AV     4'h6
`define SEQLS_C_NAV    4'h7
`define SEQLS_C_AC     4'h8
`define SEQLS_C_NAC    4'h9
`define SEQLS_C_NEG    4'hA
`define SEQLS_C_POS    4'hB
`define SEQLS_C_MV     4'hC
`define SEQLS_C_NMV    4'hD
`define SEQLS_C_NOT_CE 4'hE
`define SEQLS_C_TRUE   4'hF

`endif

/* File: core/seqls_pkg.sv */
// Types shared by the sequencer loop and stack unit and its users.
// Assumes the constants header is on the include path.
`include "seqls_consts.svh"

package seqls_pkg;

    // **************************************************************
    // Instruction kinds handed over by the decoder
    // **************************************************************
    typedef enum logic [2:0]
    {
        SEQLS_OP_SEQ   = 3'b000,
        SEQLS_OP_JUMP  = 3'b001,
        SEQLS_OP_CALL  = 3'b010,
        SEQLS_OP_RET   = 3'b011,
        SEQLS_OP_IND   = 3'b100,
        SEQLS_OP_DO    = 3'b101,
        SEQLS_OP_TEST  = 3'b110,
        SEQLS_OP_INTR  = 3'b111
    } seqls_op_t;

    // One decoded instruction, presented for one processor cycle.
    typedef struct packed
    {
        logic                      valid;
        seqls_op_t                 op;
        logic                      cond_en;
        logic [`SEQLS_COND_W-1:0]  cond;
        logic [`SEQLS_ADDR_W-1:0]  target;
        logic                      pop_pc;
        logic                      pop_cnt;
        logic                      pop_loop;
    } seqls_instr_t;

    // Arithmetic status flags.
    typedef struct packed
    {
        logic alu_zero_flag;
        logic alu_negative_flag;
        logic alu_overflow_flag;
        logic alu_carry_flag;
        logic multiplier_overflow_flag;
        logic x_input_sign_flag;
    } seqls_flags_t;

    // Loop stack entry: end address and termination field.
    typedef struct packed
    {
        logic [`SEQLS_ADDR_W-1:0] end_addr;
        logic [`SEQLS_COND_W-1:0] cond;
    } seqls_loop_t;

endpackage : seqls_pkg

/* File: core/seqls_core.sv */
// Program sequencer core: instruction pointer, return stack, loop
// counter with count stack, loop comparator with loop stack.
// Assumes decoder and flags run on clk; registers on classic Wishbone.
//
// Summary of operation
// [RULE1] 14-bit pointer with plus-one incrementer.
// [RULE2] 16-deep return stack; call pushes incrementer.
// [RULE3] Interrupt pushes unincremented current address.
// [RULE4] Return stack auto push/pop, manual pop.
// [RULE5] Pointer loads next address every cycle; here only on a valid instruction.
// [RULE6] Indirect jump loads pointer from address bus.
// [RULE7] 14-bit loop counter, post-decrement.
// [RULE8] Counter write takes low 14 bits, N.
// [RULE9] Expired when counter holds one; decrement after.
// [RULE10] Conditional jump on expired also decrements.
// [RULE11] Return, trap, arithmetic tests leave counter.
// [RULE12] Counter read anytime, upper bits zero.
// [RULE13] Counter load pushes previous into count stack.
// [RULE14] Expired true or manual pop pops count.
// [RULE15] No push while counter holds no value.
// [RULE16] Count-empty when pops reach pushes, max four.
// [RULE17] Comparator checks end against next fetch address.
// [RULE18] Loop start pushes end, condition, return address.
// [RULE19] Comparator active only with loops stacked.
// [RULE20] Termination conditions evaluated from flags.
// [RULE21] Termination field is inverse of branch test.
// [RULE22] Loop entry and exit cost no cycles.
// [RULE23] Last instruction: loop back or fall out.
// [RULE24] Taken transfer at loop end overrides loop.
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "seqls_consts.svh"

module seqls_core
    import seqls_pkg::*;
#(
    parameter int PCS_DEPTH   = `SEQLS_PCS_DEPTH,
    parameter int CNTS_DEPTH  = `SEQLS_CNTS_DEPTH,
    parameter int LOOPS_DEPTH = `SEQLS_LOOPS_DEPTH
)
(
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // Decoder, flags and indirect target.
    input  wire seqls_instr_t             instr,
    input  wire seqls_flags_t             flags,
    input  wire logic [`SEQLS_ADDR_W-1:0] program_memory_address_bus,
    // Program fetch side.
    output logic [`SEQLS_ADDR_W-1:0]      instruction_pointer_q,
    output logic [`SEQLS_ADDR_W-1:0]      fetch_addr_q,
    output logic                          loop_last_q,
    // Wishbone slave.
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [7:0]               adr_i,
    input  wire logic [3:0]               sel_i,
    input  wire logic [31:0]              dat_i,
    output logic [31:0]                   dat_o,
    output logic                          ack_o
);

    localparam int AW  = `SEQLS_ADDR_W;
    localparam int PPW = $clog2(PCS_DEPTH + 1);
    localparam int PIW = $clog2(PCS_DEPTH);
    localparam int CPW = $clog2(CNTS_DEPTH + 1);
    localparam int CIW = $clog2(CNTS_DEPTH);
    localparam int LPW = $clog2(LOOPS_DEPTH + 1);
    localparam int LIW = $clog2(LOOPS_DEPTH);

    // ******************************************************************
    // Storage
    // ******************************************************************
    logic [AW-1:0]    pcs_mem [PCS_DEPTH];
    logic [AW-1:0]    cnts_mem [CNTS_DEPTH];
    seqls_loop_t      loops_mem [LOOPS_DEPTH];
    logic [PPW-1:0]   pcs_sp_q;
    logic [CPW-1:0]   cnts_sp_q;
    logic [LPW-1:0]   loops_sp_q;
    logic             pcs_ovf_q;
    logic             cnts_ovf_q;
    logic             loops_ovf_q;
    logic [AW-1:0]    cnt_q;
    logic             cnt_valid_q;
    logic             ack_q;
    logic [31:0]      dat_q;

    // ******************************************************************
    // Combinational decode
    // ******************************************************************
    logic [AW-1:0]    incr;
    logic [AW-1:0]    next_d;
    logic [AW-1:0]    pcs_top;
    logic [AW-1:0]    cnts_top;
    seqls_loop_t      loop_top;
    logic             step;
    logic             irq;
    logic             cond_ok;
    logic             xfer;
    logic             loop_end;
    logic             term;
    logic             ce_now;
    logic             ce_tick;
    logic             pcs_push;
    logic             pcs_pop;
    logic [AW-1:0]    pcs_push_val;
    logic             cnt_load;
    logic             cnts_push;
    logic             cnts_pop;
    logic             loops_push;
    logic             loops_pop;
    logic             wb_req;

    // Branch-sense test of a condition field against the flags.
    function automatic logic branch_test(input logic [`SEQLS_COND_W-1:0] c,
                                         input seqls_flags_t f,
                                         input logic ce);
        logic lt;
        lt = f.alu_negative_flag ^ f.alu_overflow_flag;
        case (c)
            `SEQLS_C_EQ:     branch_test = f.alu_zero_flag;
            `SEQLS_C_NE:     branch_test = !f.alu_zero_flag;
            `SEQLS_C_GT:     branch_test = !(lt | f.alu_zero_flag);
            `SEQLS_C_LE:     branch_test = lt | f.alu_zero_flag;
            `SEQLS_C_LT:     branch_test = lt;
            `SEQLS_C_GE:     branch_test = !lt;
            `SEQLS_C_AV:     branch_test = f.alu_overflow_flag;
            `SEQLS_C_NAV:    branch_test = !f.alu_overflow_flag;
            `SEQLS_C_AC:     branch_test = f.alu_carry_flag;
            `SEQLS_C_NAC:    branch_test = !f.alu_carry_flag;
            `SEQLS_C_NEG:    branch_test = f.x_input_sign_flag;
            `SEQLS_C_POS:    branch_test = !f.x_input_sign_flag;
            `SEQLS_C_MV:     branch_test = f.multiplier_overflow_flag;
            `SEQLS_C_NMV:    branch_test = !f.multiplier_overflow_flag;
            `SEQLS_C_NOT_CE: branch_test = !ce;
            default:         branch_test = 1'b1;
        endcase
    endfunction : branch_test

    // Stack tops; an empty stack reads its last slot harmlessly.
    assign pcs_top  = pcs_mem[PIW'(pcs_sp_q - 1'b1)];
    assign cnts_top = cnts_mem[CIW'(cnts_sp_q - 1'b1)];
    assign loop_top = loops_mem[LIW'(loops_sp_q - 1'b1)];

    // Sequencing terms for this processor cycle.
    always_comb
    begin
        incr     = instruction_pointer_q + 1'b1;                  // see [RULE1]
        step     = instr.valid;
        irq      = step && (instr.op == SEQLS_OP_INTR);
        ce_now   = (cnt_q == `SEQLS_CE_VALUE);                    // see [RULE9]
        cond_ok  = !instr.cond_en || branch_test(instr.cond, flags, ce_now);
        xfer     = step && cond_ok && ((instr.op == SEQLS_OP_JUMP) ||
                   (instr.op == SEQLS_OP_CALL) || (instr.op == SEQLS_OP_RET) ||
                   (instr.op == SEQLS_OP_IND));
        // A taken transfer or an interrupt suppresses the loop-end action.
        loop_end = step && !irq && !xfer && loop_last_q &&
                   (loops_sp_q != '0);                            // see [RULE24]
        // Termination is the inverse of the branch sense of the field.
        term     = !branch_test(loop_top.cond, flags, ce_now);    // see [RULE20] [RULE21]
        // Only conditional jumps on CE and CE-terminated loop ends count down;
        // returns, traps and arithmetic tests leave the counter alone.
        ce_tick  = (loop_end && (loop_top.cond == `SEQLS_C_NOT_CE)) ||
                   (step && !irq && (instr.op == SEQLS_OP_JUMP) && instr.cond_en &&
                    (instr.cond == `SEQLS_C_NOT_CE));             // see [RULE10] [RULE11]
    end

    // Next address selection and stack requests.
    always_comb
    begin
        next_d       = incr;
        pcs_push     = 1'b0;
        pcs_push_val = incr;
        pcs_pop      = 1'b0;
        loops_push   = 1'b0;
        loops_pop    = 1'b0;
        if (irq)
        begin
            next_d       = instr.target;
            pcs_push     = 1'b1;
            pcs_push_val = instruction_pointer_q;                 // see [RULE3]
        end
        else if (xfer && (instr.op == SEQLS_OP_IND))
        begin
            next_d = program_memory_address_bus;                  // see [RULE6]
        end
        else if (xfer && (instr.op == SEQLS_OP_JUMP))
        begin
            next_d = instr.target;
        end
        else if (xfer && (instr.op == SEQLS_OP_CALL))
        begin
            next_d   = instr.target;
            pcs_push = 1'b1;                                      // see [RULE2]
        end
        else if (xfer && (instr.op == SEQLS_OP_RET))
        begin
            next_d  = pcs_top;
            pcs_pop = 1'b1;                                       // see [RULE4]
        end
        else if (loop_end)
        begin
            if (term)
            begin
                pcs_pop   = 1'b1;                                 // see [RULE23]
                loops_pop = 1'b1;
            end
            else
            begin
                next_d = pcs_top;                                 // see [RULE23]
            end
        end
        else if (step && (instr.op == SEQLS_OP_DO))
        begin
            pcs_push   = 1'b1;                                    // see [RULE18]
            loops_push = 1'b1;
        end
        // Manual pops yield to automatic traffic on the same stack this cycle.
        if (step && instr.pop_pc && !pcs_push && !pcs_pop)
        begin
            pcs_pop = 1'b1;                                       // see [RULE4]
        end
        if (step && instr.pop_loop && !loops_push && !loops_pop)
        begin
            loops_pop = 1'b1;
        end
    end

    // Counter load from the bus wins over any countdown or pop.
    assign wb_req    = cyc_i && stb_i && !ack_q;
    assign cnt_load  = wb_req && we_i && (adr_i == `SEQLS_OFS_CNT) && sel_i[0];
    assign cnts_push = cnt_load && cnt_valid_q;                   // see [RULE13] [RULE15]
    assign cnts_pop  = !cnt_load && ((ce_tick && ce_now) ||
                       (step && instr.pop_cnt));                  // see [RULE14]

    // ******************************************************************
    // Instruction pointer and fetch address
    // ******************************************************************
    // The pointer follows the next address once per valid instruction.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            instruction_pointer_q <= '0;
            fetch_addr_q          <= '0;
        end
        else if (step)
        begin
            instruction_pointer_q <= next_d;                      // see [RULE5]
            fetch_addr_q          <= next_d;
        end
    end

    // ******************************************************************
    // Return stack
    // ******************************************************************
    // A push on a full stack is dropped and flagged rather than wrapped.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pcs_sp_q  <= '0;
            pcs_ovf_q <= 1'b0;
        end
        else if (pcs_push)
        begin
            if (pcs_sp_q == PPW'(PCS_DEPTH))
            begin
                pcs_ovf_q <= 1'b1;
            end
            else
            begin
                pcs_mem[PIW'(pcs_sp_q)] <= pcs_push_val;          // see [RULE2] [RULE18]
                pcs_sp_q                <= pcs_sp_q + 1'b1;
            end
        end
        else if (pcs_pop && (pcs_sp_q != '0))
        begin
            pcs_sp_q <= pcs_sp_q - 1'b1;
        end
    end

    // ******************************************************************
    // Loop counter and count stack
    // ******************************************************************
    // The counter is only trusted after a load; an expiry with nothing
    // stacked leaves it invalid so the next load wastes no stack slot.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q       <= `SEQLS_CNT_RESET;
            cnt_valid_q <= 1'b0;                                  // see [RULE15]
        end
        else if (cnt_load)
        begin
            cnt_q       <= dat_i[AW-1:0];                         // see [RULE8]
            cnt_valid_q <= 1'b1;
        end
        else if (cnts_pop)
        begin
            if (cnts_sp_q != '0)
            begin
                cnt_q <= cnts_top;                                // see [RULE14]
            end
            else
            begin
                cnt_valid_q <= 1'b0;                              // see [RULE15]
            end
        end
        else if (ce_tick)
        begin
            cnt_q <= cnt_q - 1'b1;                                // see [RULE7] [RULE9]
        end
    end

    // Depth counts at most four pushes; extra pushes only set overflow.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnts_sp_q  <= '0;
            cnts_ovf_q <= 1'b0;
        end
        else if (cnts_push)
        begin
            if (cnts_sp_q == CPW'(CNTS_DEPTH))
            begin
                cnts_ovf_q <= 1'b1;                               // see [RULE16]
            end
            else
            begin
                cnts_mem[CIW'(cnts_sp_q)] <= cnt_q;               // see [RULE13]
                cnts_sp_q                 <= cnts_sp_q + 1'b1;
            end
        end
        else if (cnts_pop && (cnts_sp_q != '0))
        begin
            cnts_sp_q <= cnts_sp_q - 1'b1;                        // see [RULE16]
        end
    end

    // ******************************************************************
    // Loop stack and comparator
    // ******************************************************************
    // All loop pushes and pops ride on the instruction's own cycle.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            loops_sp_q  <= '0;
            loops_ovf_q <= 1'b0;
        end
        else if (loops_push)
        begin
            if (loops_sp_q == LPW'(LOOPS_DEPTH))
            begin
                loops_ovf_q <= 1'b1;
            end
            else
            begin
                loops_mem[LIW'(loops_sp_q)] <= {instr.target, instr.cond}; // see [RULE18] [RULE22]
                loops_sp_q                  <= loops_sp_q + 1'b1;
            end
        end
        else if (loops_pop && (loops_sp_q != '0))
        begin
            loops_sp_q <= loops_sp_q - 1'b1;                      // see [RULE22]
        end
    end

    // The comparator looks at the address about to be fetched, so the
    // flag stands during the cycle in which the last instruction runs.
    // A loop pushed this cycle is compared from the next cycle on.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            loop_last_q <= 1'b0;
        end
        else if (step)
        begin
            loop_last_q <= (loops_sp_q != '0) && !loops_pop &&
                           (next_d == loop_top.end_addr);         // see [RULE17] [RULE19]
        end
    end

    // ******************************************************************
    // Wishbone slave
    // ******************************************************************
    // One wait-free answer: ack follows the request by one edge and
    // drops the next cycle; unmapped offsets read zero and ignore writes.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end
        else
        begin
            ack_q <= wb_req;
            if (wb_req && !we_i)
            begin
                if (adr_i == `SEQLS_OFS_CNT)
                begin
                    dat_q <= {18'h0_0000, cnt_q};                 // see [RULE12]
                end
                else if (adr_i == `SEQLS_OFS_STAT)
                begin
                    dat_q                            <= '0;
                    dat_q[`SEQLS_ST_PCS_EMPTY]       <= (pcs_sp_q == '0);
                    dat_q[`SEQLS_ST_PCS_OVF]         <= pcs_ovf_q;
                    dat_q[`SEQLS_ST_CNTS_EMPTY]      <= (cnts_sp_q == '0); // see [RULE16]
                    dat_q[`SEQLS_ST_CNTS_OVF]        <= cnts_ovf_q;
                    dat_q[`SEQLS_ST_LOOPS_EMPTY]     <= (loops_sp_q == '0);
                    dat_q[`SEQLS_ST_LOOPS_OVF]       <= loops_ovf_q;
                    dat_q[`SEQLS_ST_CNT_VALID]       <= cnt_valid_q;
                end
                else if (adr_i == `SEQLS_OFS_IP)
                begin
                    dat_q <= {18'h0_0000, instruction_pointer_q};
                end
                else
                begin
                    dat_q <= '0;
                end
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

endmodule : seqls_core

/* File: test/seqls_chk_sva.sv */
// Port checker for the sequencer core.
// Assumes one clock and the reset rstn.
`timescale 1ns/100ps
module seqls_chk
    import seqls_pkg::*;
(
    // Inputs of the core.
    input wire logic         clk,
    input wire logic         rstn,
    input wire seqls_instr_t instr,
    input wire logic [13:0]  program_memory_address_bus,
    input wire logic         cyc_i,
    input wire logic         stb_i,
    // Outputs of the core.
    input wire logic [13:0]  instruction_pointer_q,
    input wire logic         loop_last_q,
    input wire logic         ack_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Short names; a loop end step is left to the bench model.
    wire        v  = instr.valid;
    wire        s  = v && !loop_last_q;
    wire [13:0] ip = instruction_pointer_q;
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("long ack");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_ip_hold: assert property (
        !v |=> ip == $past(ip)) else $error("pointer moved");
    a_seq_incr: assert property (
        s && instr.op == SEQLS_OP_SEQ |=> ip == $past(ip) + 14'h0001) else $error("no step");
    a_do_entry: assert property (
        s && instr.op == SEQLS_OP_DO |=> ip == $past(ip) + 14'h0001) else $error("do stall");
    a_call_wins: assert property (
        v && instr.op == SEQLS_OP_CALL && !instr.cond_en |=> ip == $past(instr.target))
        else $error("call lost");
    a_ind_jump: assert property (
        v && instr.op == SEQLS_OP_IND && !instr.cond_en |=> ip == $past(program_memory_address_bus))
        else $error("indirect lost");
    a_intr_vec: assert property (
        v && instr.op == SEQLS_OP_INTR |=> ip == $past(instr.target)) else $error("vector lost");
endmodule : seqls_chk

bind seqls_core seqls_chk u_chk (.clk(clk), .rstn(rstn), .instr(instr), .cyc_i(cyc_i),
    .program_memory_address_bus(program_memory_address_bus), .stb_i(stb_i), .ack_o(ack_o),
    .instruction_pointer_q(instruction_pointer_q), .loop_last_q(loop_last_q));

/* File: test/seqls_far.sv */
// Far side: condition flags and the indirect address bus.
// Assumes the bench sets requests just after rising edges.
`timescale 1ns/100ps
module seqls_far
    import seqls_pkg::*;
(
    // Requests from the bench.
    input  wire logic         clk,
    input  wire logic         ind_en,
    input  wire logic [13:0]  ind_addr,
    input  wire seqls_flags_t flags_in,
    // Lines into the core.
    output seqls_flags_t      flags,
    output logic [13:0]       program_memory_address_bus
);
    logic [13:0] junk_q = 14'h2aaa;

    // A released bus changes every cycle, so a stale target never passes.
    always @(posedge clk)
        junk_q <= ~junk_q + 14'h0003;

    // Flags are plain levels.
    assign flags = flags_in;
    assign program_memory_address_bus = ind_en ? ind_addr : junk_q;
endmodule : seqls_far

/* File: test/tb.sv */
// Bench: steps and bus cycles against a queue model of the sequencer.
// Assumes core, checker and far side are compiled first.
`timescale 1ns/100ps
module tb
    import seqls_pkg::*;
;
    logic         clk = 1'b0, rstn = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ie = 1'b0;
    logic [7:0]   adr_i = 8'h00;
    logic [13:0]  ia = 14'h0000, pmab, ip_q, fa_q;
    logic [31:0]  dat_i = 32'h0000_0000, dat_o, r, seed = 32'h22b9_dd2f;
    logic         ack_o, ll_q;
    seqls_instr_t instr = '0;
    seqls_flags_t fl = '0, flags;
    int           n_fail = 0, check_count = 0, ip = 0, cnt = 0, rs[$], cs[$], le[$];
    bit           cv = 1'b0;

    // The processor clock, 100 ns.
    always #50 clk = ~clk;

    seqls_far u_far (.clk(clk), .ind_en(ie), .ind_addr(ia), .flags_in(fl), .flags(flags),
        .program_memory_address_bus(pmab));
    seqls_core DUT (.clk(clk), .rstn(rstn), .instr(instr), .flags(flags),
        .program_memory_address_bus(pmab), .instruction_pointer_q(ip_q), .fetch_addr_q(fa_q),
        .loop_last_q(ll_q), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Expected status word.
    function automatic logic [31:0] sts();
        return {25'h0, cv, 1'b0, le.size() == 0, 1'b0, cs.size() == 0, 1'b0, rs.size() == 0};
    endfunction : sts

    // Expiry test: count down, or reload from the count stack when expired.
    function automatic bit cexp();
        bit e = (cnt == 1);
        if (!e)
            cnt = cnt - 1;
        else if (cs.size() != 0)
            cnt = cs.pop_back();
        else
            cv = 1'b0;
        return e;
    endfunction : cexp

    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : ck

    // One classic cycle; the release at the ack edge leaves one idle cycle.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        instr <= '0;
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        // Only the watchdog ends a wait that never sees ack.
        do @(posedge clk);
        while (ack_o !== 1'b1);
        r = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask : wb

    // Counter load: a valid old value goes onto the count stack.
    task automatic ld(input logic [31:0] d);
        if (cv && cs.size() < 4)
            cs.push_back(cnt);
        cnt = d[13:0];
        cv = 1'b1;
        wb(1'b1, 8'h00, d);
        wb(1'b0, 8'h00, 0);
        ck(r, cnt);
    endtask : ld

    // One step: check the last result, then advance the model.
    task automatic st(input seqls_op_t o, input int t = 0, input bit c = 0);
        bit lst;
        int n;
        @(posedge clk);
        r = xs();
        instr <= {1'b1, o, c, 4'he, t[13:0], 3'b000};
        {ie, ia, fl} <= {o == SEQLS_OP_IND, r[13:0], r[21:16]};
        @(negedge clk);
        lst = le.size() != 0 && ip == le[$];
        ck(ip_q, ip);
        ck(fa_q, ip);
        ck(ll_q, lst);
        n = ip + 1;
        if (o == SEQLS_OP_CALL || o == SEQLS_OP_DO)
            rs.push_back(n);
        if (o == SEQLS_OP_INTR)
            rs.push_back(ip);
        if (o == SEQLS_OP_DO)
            le.push_back(t);
        if (o == SEQLS_OP_IND)
            n = r[13:0];
        if (o inside {SEQLS_OP_CALL, SEQLS_OP_INTR} || (o == SEQLS_OP_JUMP && !cexp()))
            n = t;
        if (o == SEQLS_OP_RET && (!c || cnt != 1))
            n = rs.pop_back();
        if (lst && o == SEQLS_OP_SEQ)
        begin
            if (!cexp())
                n = rs[$];
            else
            begin
                void'(le.pop_back());
                void'(rs.pop_back());
            end
        end
        ip = n & 16'h3fff;
    endtask : st

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // Watchdog, far beyond the hundred or so cycles the run needs.
    initial
    begin
        #400_000;
        n_fail++;
        test_done();
    end

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        wb(1'b0, 8'h04, 0);
        ck(r, sts());
        wb(1'b1, 8'h04, 32'hffff_ffff);
        wb(1'b0, 8'h0c, 0);
        ck(r, 0);
        repeat (3) ld(xs());
        ld(3);
        st(SEQLS_OP_DO, ip + 3);
        repeat (12) st(SEQLS_OP_SEQ);
        st(SEQLS_OP_CALL, 14'h0100);
        st(SEQLS_OP_RET);
        st(SEQLS_OP_INTR, 2);
        st(SEQLS_OP_RET);
        st(SEQLS_OP_IND);
        ld(2);
        repeat (2) st(SEQLS_OP_JUMP, 14'h0200, 1);
        ld(5);
        st(SEQLS_OP_CALL, 14'h0300);
        st(SEQLS_OP_RET, 0, 1);
        st(SEQLS_OP_SEQ);
        wb(1'b0, 8'h00, 0);
        ck(r, cnt);
        wb(1'b0, 8'h04, 0);
        ck(r, sts());
        test_done();
    end
endmodule : tb
